// ===== tb/sdcd_link_properties.sv
// link protocol checks between the controller end and the device end
module sdcd_link_properties
    import sdcd_pkg::*;
(
    // clock and reset
    input wire logic linkClk,
    input wire logic linkClkN,
    input wire logic rst,
    // command and address
    input wire logic chipSelectN,
    input wire logic rowStrobeN,
    input wire logic colStrobeN,
    input wire logic writeEnableN,
    input wire logic [ROW_W-1:0] addr,
    // data and strobe drive
    input wire logic ctrlDqOe,
    input wire logic [LANES-1:0] ctrlStrobeOe,
    input wire logic devDqOe,
    input wire logic [LANES-1:0] devStrobeOut,
    input wire logic [LANES-1:0] devStrobeOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // decode helpers
    default clocking cb @(posedge linkClk); endclocking
    default disable iff (rst);
    logic isRead;
    logic isWrite;
    assign isRead = !chipSelectN && {rowStrobeN, colStrobeN, writeEnableN} == 3'b101;
    assign isWrite = !chipSelectN && {rowStrobeN, colStrobeN, writeEnableN} == 3'b100;

    // ==========================================================
    // properties
    a_read_chop_len: assert property (
        isRead && !addr[BC_BIT] |=> devDqOe [*4] ##1 !devDqOe) else $error("chopped read beat count wrong");
    a_read_full_len: assert property (
        isRead && addr[BC_BIT] |=> devDqOe [*8] ##1 !devDqOe) else $error("full read beat count wrong");
    a_read_strobe_toggle: assert property (
        isRead |=> devStrobeOe == 2'h3 && devStrobeOut == 2'h3 ##1 devStrobeOut == 2'h0)
        else $error("read strobe not toggling with data");
    a_write_chop_drive: assert property (
        isWrite && !addr[BC_BIT] |=> (ctrlDqOe && ctrlStrobeOe == 2'h3 && !devDqOe) [*4] ##1 !ctrlDqOe)
        else $error("chopped write drive wrong");
    a_write_full_drive: assert property (
        isWrite && addr[BC_BIT] |=> ctrlDqOe [*8] ##1 !ctrlDqOe) else $error("full write drive wrong");
    a_cmd_one_cycle: assert property (
        !chipSelectN |=> chipSelectN) else $error("command held past one link cycle");
    a_clk_pair_apart: assert property (
        linkClkN != linkClk) else $error("link clock pair not complementary");
    a_no_drive_clash: assert property (
        !(devDqOe && ctrlDqOe)) else $error("both ends drive data");
    a_strobe_lanes_match: assert property (
        devStrobeOe[0] |-> devStrobeOut[0] == devStrobeOut[1]) else $error("strobe lanes differ");
endmodule

// ===== tb/tb_top.sv
// self-checking bench joining controller and device over the link
module tb_top
    import sdcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and bookkeeping
    typedef struct packed {
        sdcd_cmd_e kind; logic [2:0] bank; logic [15:0] addr; logic ap; logic fb; logic all;
        logic [15:0] wd; logic [1:0] wm; logic [7:0] banks; logic [15:0] expData;
    } sdcd_row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqReady;
    sdcd_cmd_e reqKind = CMD_NOP;
    logic [2:0] reqBank = 3'h0;
    logic [15:0] reqAddr = 16'h0000;
    logic reqAutoPre = 1'b0;
    logic reqFullBurst = 1'b0;
    logic reqAllBanks = 1'b0;
    logic [15:0] wrData = 16'h0000;
    logic [1:0] wrMask = 2'h0;
    logic [15:0] rdData;
    logic rdValid;
    logic cmdValid;
    sdcd_snap_s cmdInfo;
    sdcd_snap_s rep[$];
    logic [15:0] rdExp = 16'h0000;
    int rdBeats = 0;
    int errors = 0;
    int nCompared = 0;
    // masks apply per byte lane, so the stored word is built lane by lane
    sdcd_row_s rows [15] = '{
        '{CMD_ACT, 3'h3, 16'hbeef, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00, 16'h0000},
        '{CMD_ACT, 3'h7, 16'h8001, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h08, 16'h0000},
        '{CMD_MRS, 3'h2, 16'h1234, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h88, 16'h0000},
        '{CMD_WRITE, 3'h3, 16'h03ff, 1'b0, 1'b1, 1'b0, 16'ha5c3, 2'h0, 8'h88, 16'ha5c3},
        '{CMD_WRITE, 3'h3, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h1100, 2'h2, 8'h88, 16'ha500},
        '{CMD_WRITE, 3'h3, 16'h0155, 1'b0, 1'b0, 1'b0, 16'hffee, 2'h1, 8'h88, 16'hff00},
        '{CMD_WRITE, 3'h3, 16'h0200, 1'b1, 1'b1, 1'b0, 16'h1234, 2'h3, 8'h88, 16'hff00},
        '{CMD_ACT, 3'h3, 16'h0f0f, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h80, 16'h0000},
        '{CMD_READ, 3'h3, 16'h0001, 1'b1, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h88, 16'hff00},
        '{CMD_READ, 3'h7, 16'h03ff, 1'b0, 1'b1, 1'b0, 16'h0000, 2'h0, 8'h80, 16'hff00},
        '{CMD_PRE, 3'h7, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h80, 16'h0000},
        '{CMD_ACT, 3'h0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00, 16'h0000},
        '{CMD_ACT, 3'h5, 16'hffff, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h01, 16'h0000},
        '{CMD_PRE, 3'h0, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h0000, 2'h0, 8'h21, 16'h0000},
        '{CMD_ACT, 3'h1, 16'h0001, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00, 16'h0000}};

    // ==========================================================
    // design and link
    sdcd_link_if i_sdcd_link_if();
    sdcd_controller #(.LINK_HALF(2)) i_sdcd_controller(.core_clk, .rst, .link(i_sdcd_link_if), .reqValid,
        .reqReady, .reqKind, .reqBank, .reqAddr, .reqAutoPre, .reqFullBurst, .reqAllBanks, .wrData, .wrMask,
        .rdData, .rdValid);
    sdcd_device i_sdcd_device(.core_clk, .rst, .link(i_sdcd_link_if), .cmdValid, .cmdInfo);
    sdcd_link_properties i_sdcd_link_properties(.linkClk(i_sdcd_link_if.linkClk),
        .linkClkN(i_sdcd_link_if.linkClkN), .rst, .chipSelectN(i_sdcd_link_if.chipSelectN),
        .rowStrobeN(i_sdcd_link_if.rowStrobeN), .colStrobeN(i_sdcd_link_if.colStrobeN),
        .writeEnableN(i_sdcd_link_if.writeEnableN), .addr(i_sdcd_link_if.addr),
        .ctrlDqOe(i_sdcd_link_if.ctrlDqOe), .ctrlStrobeOe(i_sdcd_link_if.ctrlStrobeOe),
        .devDqOe(i_sdcd_link_if.devDqOe), .devStrobeOut(i_sdcd_link_if.devStrobeOut),
        .devStrobeOe(i_sdcd_link_if.devStrobeOe));

    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // entered at a falling edge; request held until the edge that takes it
    task automatic issue(input sdcd_row_s r);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk("reqReady", 16'h1, 16'(reqReady));
        reqKind = r.kind;
        {reqBank, reqAddr, reqAutoPre, reqFullBurst, reqAllBanks} = {r.bank, r.addr, r.ap, r.fb, r.all};
        {wrData, wrMask, reqValid} = {r.wd, r.wm, 1'b1};
        @(posedge core_clk);
        @(negedge core_clk);
        reqValid = 1'b0;
    endtask

    task automatic get_rep(output sdcd_snap_s s);
        int n;
        n = 0;
        s = '0;
        while (rep.size() == 0 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        chk("reportSeen", 16'h1, 16'(rep.size() != 0));
        if (rep.size() != 0) begin
            s = rep.pop_front();
        end
    endtask

    // long settle covers a full burst plus the precharge delay
    task automatic run_row(input sdcd_row_s r);
        sdcd_snap_s s;
        rdExp = r.expData;
        rdBeats = 0;
        issue(r);
        get_rep(s);
        chk("kind", 16'(r.kind), 16'(s.kind));
        chk("bank", 16'(r.bank), 16'(s.bank));
        chk("bankActive", 16'(r.banks), 16'(s.bankActive));
        if (r.kind == CMD_ACT || r.kind == CMD_MRS) chk("addr", r.addr, s.addr);
        if (r.kind == CMD_READ || r.kind == CMD_WRITE) begin
            chk("col", 16'(r.addr[9:0]), 16'(s.col));
            chk("autoPre", 16'(r.ap), 16'(s.autoPre));
            chk("fullBurst", 16'(r.fb), 16'(s.fullBurst));
        end
        if (r.kind == CMD_PRE) chk("allBanks", 16'(r.all), 16'(s.allBanks));
        if (r.kind == CMD_WRITE) begin
            get_rep(s);
            chk("doneKind", 16'(CMD_WDONE), 16'(s.kind));
            chk("stored", r.expData, s.data);
        end
        repeat (60) @(negedge core_clk);
        if (r.kind == CMD_READ) chk("rdBeats", r.fb ? 16'h8 : 16'h4, 16'(rdBeats));
    endtask

    // ==========================================================
    // monitors, clock, watchdog
    always @(negedge core_clk) begin
        if (cmdValid === 1'b1) rep.push_back(cmdInfo);
        if (rdValid === 1'b1) begin
            rdBeats++;
            chk("rdData", rdExp, rdData);
        end
    end

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #100us;
        errors++;
        complete_run();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        issue('{CMD_NOP, 3'h6, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00, 16'h0000});
        repeat (40) @(negedge core_clk);
        chk("nopReports", 16'h0, 16'(rep.size()));
        run_row('{CMD_ACT, 3'h4, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h02, 16'h0000});
        // reset lands in the middle of a full read burst
        rdExp = 16'hff00;
        issue('{CMD_READ, 3'h4, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0000, 2'h0, 8'h12, 16'hff00});
        repeat (12) @(negedge core_clk);
        rst = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("rstIdle", 16'h0001, 16'({cmdValid, rdValid, i_sdcd_link_if.devDqOe, reqReady}));
        chk("rstInfo", 16'h0, 16'(cmdInfo !== '0));
        rst = 1'b0;
        rep.delete();
        run_row('{CMD_ACT, 3'h6, 16'h00aa, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00, 16'h0000});
        complete_run();
    end
endmodule

// ===== verilog/sdcd_controller.sv
// controller end: makes the link clock, issues commands and moves data beats
module sdcd_controller
    import sdcd_pkg::*;
#(
    parameter int LINK_HALF = LINK_HALF_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    sdcd_link_if.ctrl link,
    // request
    input wire logic reqValid,
    output logic reqReady,
    input wire sdcd_cmd_e reqKind,
    input wire logic [BANK_W-1:0] reqBank,
    input wire logic [ROW_W-1:0] reqAddr,
    input wire logic reqAutoPre,
    input wire logic reqFullBurst,
    input wire logic reqAllBanks,
    input wire logic [DQ_W-1:0] wrData,
    input wire logic [LANES-1:0] wrMask,
    // read answer
    output logic [DQ_W-1:0] rdData,
    output logic rdValid
);
    typedef enum logic [1:0] {C_IDLE, C_ARM, C_BEAT, C_TAIL} sdcd_cstate_e;

    // ==========================================================
    // link clock divider
    logic [7:0] divCnt_r;
    logic linkClk_r;
    logic fallNow;
    localparam logic [7:0] DIV_LAST = 8'(LINK_HALF - 1);

    assign fallNow = (divCnt_r == DIV_LAST) && linkClk_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 8'h00;
            linkClk_r <= 1'b0;
        end else if (divCnt_r == DIV_LAST) begin
            divCnt_r <= 8'h00;
            linkClk_r <= ~linkClk_r;
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
        end
    end

    // ==========================================================
    // sequencer
    sdcd_cstate_e state_r;
    sdcd_cmd_e kind_r;
    logic [BANK_W-1:0] bank_r;
    logic [ROW_W-1:0] addrHold_r;
    logic [DQ_W-1:0] wrData_r;
    logic [LANES-1:0] wrMask_r;
    logic [BEAT_W-1:0] beats_r;
    logic csN_r, rasN_r, casN_r, weN_r;
    logic [ROW_W-1:0] addr_r;
    logic [BANK_W-1:0] bankOut_r;
    logic dqOe_r;
    logic [LANES-1:0] mask_r;
    logic strobe_r;
    logic isBurst;
    logic [3:0] code;
    logic [ROW_W-1:0] addrCmd;

    assign reqReady = (state_r == C_IDLE);
    assign isBurst = (kind_r == CMD_READ) || (kind_r == CMD_WRITE);

    // command code {cs, ras, cas, we} and address word per kind
    always_comb begin
        code = 4'hf;
        addrCmd = '0;
        case (kind_r)
            CMD_ACT: begin
                code = 4'h3;
                addrCmd = addrHold_r;
            end
            CMD_PRE: begin
                code = 4'h2;
                addrCmd[AP_BIT] = reqAllBanksHold(addrHold_r);
            end
            CMD_READ, CMD_WRITE: begin
                code = (kind_r == CMD_READ) ? 4'h5 : 4'h4;
                addrCmd[COL_W-1:0] = addrHold_r[COL_W-1:0];
                addrCmd[AP_BIT] = addrHold_r[AP_BIT];
                addrCmd[BC_BIT] = addrHold_r[BC_BIT];
            end
            CMD_MRS: begin
                code = 4'h0;
                addrCmd = addrHold_r;
            end
            default: begin
                code = 4'h7;
            end
        endcase
    end

    function automatic logic reqAllBanksHold(input logic [ROW_W-1:0] a);
        reqAllBanksHold = a[AP_BIT];
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= C_IDLE;
            kind_r <= CMD_NOP;
            bank_r <= '0;
            addrHold_r <= '0;
            wrData_r <= DATA_RST;
            wrMask_r <= '0;
            beats_r <= '0;
            csN_r <= 1'b1;
            rasN_r <= 1'b1;
            casN_r <= 1'b1;
            weN_r <= 1'b1;
            addr_r <= '0;
            bankOut_r <= '0;
            dqOe_r <= 1'b0;
            mask_r <= '0;
            strobe_r <= 1'b0;
            rdData <= DATA_RST;
            rdValid <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            case (state_r)
                C_IDLE: begin
                    if (reqValid) begin
                        state_r <= C_ARM;
                        kind_r <= reqKind;
                        bank_r <= reqBank;
                        addrHold_r <= reqAddr;
                        // row and opcode words travel whole; only column commands and precharge reuse bits
                        if (reqKind == CMD_PRE) begin
                            addrHold_r[AP_BIT] <= reqAllBanks;
                        end else if (reqKind == CMD_READ || reqKind == CMD_WRITE) begin
                            addrHold_r[AP_BIT] <= reqAutoPre;
                            addrHold_r[BC_BIT] <= reqFullBurst;
                        end
                        wrData_r <= wrData;
                        wrMask_r <= wrMask;
                    end
                end
                C_ARM: begin
                    if (fallNow) begin
                        {csN_r, rasN_r, casN_r, weN_r} <= code;
                        addr_r <= addrCmd;
                        bankOut_r <= bank_r;
                        beats_r <= addrHold_r[BC_BIT] ? BURST_FULL : BURST_CHOP;
                        state_r <= isBurst ? C_BEAT : C_TAIL;
                    end
                end
                C_BEAT: begin
                    if (fallNow) begin
                        csN_r <= 1'b1;
                        beats_r <= beats_r - 4'h1;
                        if (kind_r == CMD_WRITE) begin
                            dqOe_r <= 1'b1;
                            mask_r <= wrMask_r;
                            strobe_r <= ~strobe_r;
                        end else begin
                            rdData <= link.dq;
                            rdValid <= 1'b1;
                        end
                        if (beats_r == 4'h1) begin
                            state_r <= (kind_r == CMD_WRITE) ? C_TAIL : C_IDLE;
                        end
                    end
                end
                default: begin
                    if (fallNow) begin
                        csN_r <= 1'b1;
                        dqOe_r <= 1'b0;
                        mask_r <= '0;
                        strobe_r <= 1'b0;
                        state_r <= C_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // link drive
    assign link.linkClk = linkClk_r;
    assign link.linkClkN = ~linkClk_r;
    assign link.chipSelectN = csN_r;
    assign link.rowStrobeN = rasN_r;
    assign link.colStrobeN = casN_r;
    assign link.writeEnableN = weN_r;
    assign link.bankSelect = bankOut_r;
    assign link.addr = addr_r;
    assign link.lowerByteWriteMask = mask_r[0];
    assign link.upperByteWriteMask = mask_r[1];
    assign link.ctrlDqOut = wrData_r;
    assign link.ctrlDqOe = dqOe_r;
    assign link.ctrlStrobeOut = {LANES{strobe_r}};
    assign link.ctrlStrobeOe = {LANES{dqOe_r}};
endmodule

// ===== verilog/sdcd_device.sv
// memory device end: latches and decodes commands, tracks banks, masks writes
module sdcd_device
    import sdcd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    sdcd_link_if.dev link,
    // decoded command report, core clock
    output logic cmdValid,
    output sdcd_snap_s cmdInfo
);
    // ==========================================================
    // command decode on the link clock
    sdcd_cmd_e cmdNow;
    logic [BANK_W-1:0] bankNow;
    logic [NUM_BANKS-1:0] bankOneHot;
    logic autoPrechargeSelect;
    logic burstChopSelectN;

    assign bankNow = link.bankSelect;
    assign bankOneHot = NUM_BANKS'(1) << bankNow;
    assign autoPrechargeSelect = link.addr[AP_BIT];
    assign burstChopSelectN = link.addr[BC_BIT];

    always_comb begin
        cmdNow = CMD_NOP;
        if (!link.chipSelectN) begin
            case ({link.rowStrobeN, link.colStrobeN, link.writeEnableN})
                3'b011: cmdNow = CMD_ACT;
                3'b010: cmdNow = CMD_PRE;
                3'b101: cmdNow = CMD_READ;
                3'b100: cmdNow = CMD_WRITE;
                3'b000: cmdNow = CMD_MRS;
                3'b111: cmdNow = CMD_NOP;
                default: cmdNow = CMD_OTHER;
            endcase
        end
    end

    // ==========================================================
    // burst tracking
    logic [BEAT_W-1:0] beats_r;
    logic rdBurst_r;
    logic wrBurst_r;
    logic [BANK_W-1:0] burstBank_r;
    logic burstAutoPre_r;
    logic burstEnd;

    assign burstEnd = (rdBurst_r || wrBurst_r) && (beats_r == 4'h1);

    // rising true clock is the crossing point; the complement only mirrors it
    always_ff @(posedge link.linkClk or posedge rst) begin
        if (rst) begin
            beats_r <= '0;
            rdBurst_r <= 1'b0;
            wrBurst_r <= 1'b0;
            burstBank_r <= '0;
            burstAutoPre_r <= 1'b0;
        end else if (cmdNow == CMD_READ || cmdNow == CMD_WRITE) begin
            beats_r <= burstChopSelectN ? BURST_FULL : BURST_CHOP;
            rdBurst_r <= (cmdNow == CMD_READ);
            wrBurst_r <= (cmdNow == CMD_WRITE);
            burstBank_r <= bankNow;
            burstAutoPre_r <= autoPrechargeSelect;
        end else if (rdBurst_r || wrBurst_r) begin
            beats_r <= beats_r - 4'h1;
            if (burstEnd) begin
                rdBurst_r <= 1'b0;
                wrBurst_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // bank state and precharge timing
    logic [NUM_BANKS-1:0] bankActive_r;
    logic [NUM_BANKS-1:0] pendMask_r;
    logic [BEAT_W-1:0] preTimer_r;
    logic [NUM_BANKS-1:0] preStart;
    logic preDone;

    always_comb begin
        preStart = BANKS_IDLE;
        if (cmdNow == CMD_PRE) begin
            preStart = autoPrechargeSelect ? BANKS_ALL : bankOneHot;
        end else if (burstEnd && burstAutoPre_r) begin
            preStart = NUM_BANKS'(1) << burstBank_r;
        end
    end

    assign preDone = (preTimer_r == 4'h1);

    always_ff @(posedge link.linkClk or posedge rst) begin
        if (rst) begin
            bankActive_r <= BANKS_IDLE;
            pendMask_r <= BANKS_IDLE;
            preTimer_r <= '0;
        end else begin
            if (preStart != BANKS_IDLE) begin
                // a new precharge restarts the wait for every pending bank, unless that wait ends in the same cycle
                pendMask_r <= (preDone ? BANKS_IDLE : pendMask_r) | preStart;
                preTimer_r <= PRE_CYCLES;
            end else if (preTimer_r != '0) begin
                preTimer_r <= preTimer_r - 4'h1;
                if (preDone) begin
                    pendMask_r <= BANKS_IDLE;
                end
            end
            if (cmdNow == CMD_ACT) begin
                bankActive_r <= (preDone ? (bankActive_r & ~pendMask_r) : bankActive_r) | bankOneHot;
            end else if (preDone) begin
                bankActive_r <= bankActive_r & ~pendMask_r;
            end
        end
    end

    // ==========================================================
    // write capture with byte masks, read drive
    logic [DQ_W-1:0] dataLatch_r;
    logic [DQ_W-1:0] dataNxt;
    logic [LANES-1:0] laneMask;
    logic [DQ_W-1:0] dqOut_r;
    logic dqOe_r;
    logic strobe_r;

    assign laneMask = {link.upperByteWriteMask, link.lowerByteWriteMask};

    // lane 0 is the low byte, lane 1 the high byte
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            always_comb begin
                dataNxt[g*8 +: 8] = dataLatch_r[g*8 +: 8];
                if (wrBurst_r && !laneMask[g]) begin
                    dataNxt[g*8 +: 8] = link.dq[g*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge link.linkClk or posedge rst) begin
        if (rst) begin
            dataLatch_r <= DATA_RST;
        end else begin
            dataLatch_r <= dataNxt;
        end
    end

    // data and strobe change on the same edge, so they leave edge-aligned
    always_ff @(posedge link.linkClk or posedge rst) begin
        if (rst) begin
            dqOut_r <= DATA_RST;
            dqOe_r <= 1'b0;
            strobe_r <= 1'b0;
        end else if (cmdNow == CMD_READ) begin
            dqOut_r <= dataLatch_r;
            dqOe_r <= 1'b1;
            strobe_r <= 1'b1;
        end else if (rdBurst_r && !burstEnd) begin
            dqOut_r <= dataLatch_r;
            strobe_r <= ~strobe_r;
        end else begin
            dqOe_r <= 1'b0;
            strobe_r <= 1'b0;
        end
    end

    assign link.devDqOut = dqOut_r;
    assign link.devDqOe = dqOe_r;
    assign link.devStrobeOut = {LANES{strobe_r}};
    assign link.devStrobeOe = {LANES{dqOe_r}};

    // ==========================================================
    // report snapshot, link side
    sdcd_snap_s snap_r;
    logic evtTgl_r;
    logic reportNow;

    assign reportNow = (cmdNow != CMD_NOP) || (wrBurst_r && burstEnd);

    always_ff @(posedge link.linkClk or posedge rst) begin
        if (rst) begin
            snap_r <= '0;
            evtTgl_r <= 1'b0;
        end else if (reportNow) begin
            evtTgl_r <= ~evtTgl_r;
            snap_r.kind <= (cmdNow != CMD_NOP) ? cmdNow : CMD_WDONE;
            snap_r.bank <= (cmdNow != CMD_NOP) ? bankNow : burstBank_r;
            snap_r.addr <= link.addr;
            snap_r.col <= link.addr[COL_W-1:0];
            snap_r.autoPre <= autoPrechargeSelect;
            snap_r.fullBurst <= burstChopSelectN;
            snap_r.allBanks <= (cmdNow == CMD_PRE) && autoPrechargeSelect;
            snap_r.bankActive <= bankActive_r;
            snap_r.data <= dataNxt;
        end
    end

    // ==========================================================
    // crossing to core clock: toggle through three flops, snapshot held still
    // the snapshot is stable for a whole link cycle, longer than the sync delay
    logic tglSync1_r;
    logic tglSync2_r;
    logic tglSync3_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tglSync1_r <= 1'b0;
            tglSync2_r <= 1'b0;
            tglSync3_r <= 1'b0;
        end else begin
            tglSync1_r <= evtTgl_r;
            tglSync2_r <= tglSync1_r;
            tglSync3_r <= tglSync2_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmdValid <= 1'b0;
            cmdInfo <= '0;
        end else begin
            cmdValid <= tglSync2_r ^ tglSync3_r;
            if (tglSync2_r ^ tglSync3_r) begin
                cmdInfo <= snap_r;
            end
        end
    end
endmodule

// ===== verilog/sdcd_link_if.sv
// link wires between controller end and memory device end
interface sdcd_link_if;
    import sdcd_pkg::*;
    // ==========================================================
    // clock, command and address, driven by the controller
    logic linkClk;
    logic linkClkN;
    logic chipSelectN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeEnableN;
    logic [BANK_W-1:0] bankSelect;
    logic [ROW_W-1:0] addr;
    logic lowerByteWriteMask;
    logic upperByteWriteMask;
    // ==========================================================
    // two-way data and strobes, one driver set per end
    logic [DQ_W-1:0] ctrlDqOut;
    logic ctrlDqOe;
    logic [LANES-1:0] ctrlStrobeOut;
    logic [LANES-1:0] ctrlStrobeOe;
    logic [DQ_W-1:0] devDqOut;
    logic devDqOe;
    logic [LANES-1:0] devStrobeOut;
    logic [LANES-1:0] devStrobeOe;
    // ==========================================================
    // resolved wire levels; undriven data and true strobe wires read low, the strobe complements read high
    logic [DQ_W-1:0] dq;
    logic lowerByteStrobe;
    logic upperByteStrobe;
    logic lowerByteStrobeN;
    logic upperByteStrobeN;

    assign dq = devDqOe ? devDqOut : (ctrlDqOe ? ctrlDqOut : '0);
    assign lowerByteStrobe = devStrobeOe[0] ? devStrobeOut[0] : (ctrlStrobeOe[0] & ctrlStrobeOut[0]);
    assign upperByteStrobe = devStrobeOe[1] ? devStrobeOut[1] : (ctrlStrobeOe[1] & ctrlStrobeOut[1]);
    assign lowerByteStrobeN = ~lowerByteStrobe;
    assign upperByteStrobeN = ~upperByteStrobe;

    modport ctrl (
        output linkClk, linkClkN, chipSelectN, rowStrobeN, colStrobeN, writeEnableN,
        output bankSelect, addr, lowerByteWriteMask, upperByteWriteMask,
        output ctrlDqOut, ctrlDqOe, ctrlStrobeOut, ctrlStrobeOe,
        input dq, lowerByteStrobe, upperByteStrobe
    );
    modport dev (
        input linkClk, linkClkN, chipSelectN, rowStrobeN, colStrobeN, writeEnableN,
        input bankSelect, addr, lowerByteWriteMask, upperByteWriteMask,
        output devDqOut, devDqOe, devStrobeOut, devStrobeOe,
        input dq, lowerByteStrobe, upperByteStrobe
    );
endinterface

// ===== verilog/sdcd_pkg.sv
// shared constants and types for the command and address decode link
package sdcd_pkg;
    // ==========================================================
    // widths
    localparam int ROW_W = 16;
    localparam int COL_W = 10;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int BEAT_W = 4;

    // ==========================================================
    // address bit positions with extra meaning
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;

    // ==========================================================
    // counts: bursts and precharge in link clock cycles, link half period in core clock cycles
    localparam logic [BEAT_W-1:0] BURST_FULL = 4'h8;
    localparam logic [BEAT_W-1:0] BURST_CHOP = 4'h4;
    localparam logic [BEAT_W-1:0] PRE_CYCLES = 4'h2;
    localparam int LINK_HALF_DEF = 2;

    // ==========================================================
    // reset values and the all-bank precharge mask
    localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;
    localparam logic [NUM_BANKS-1:0] BANKS_ALL = 8'hff;
    localparam logic [DQ_W-1:0] DATA_RST = 16'h0000;

    // ==========================================================
    // commands
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_PRE,
        CMD_READ,
        CMD_WRITE,
        CMD_MRS,
        CMD_WDONE,
        CMD_OTHER
    } sdcd_cmd_e;

    typedef struct packed {
        sdcd_cmd_e kind;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] addr;
        logic [COL_W-1:0] col;
        logic autoPre;
        logic fullBurst;
        logic allBanks;
        logic [NUM_BANKS-1:0] bankActive;
        logic [DQ_W-1:0] data;
    } sdcd_snap_s;
endpackage
